//--- logic/mlsc_pkg.sv
// shared constants and types of the module low-speed control block
package mlsc_pkg;
  // core clock and timing
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned RST_MIN_TIME_NS = 10_000;
  localparam int unsigned RST_MIN_CYCLES  =
    (RST_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_TIME_MS    = 2000;
  localparam int unsigned INIT_CYCLES     = INIT_TIME_MS * (CLK_HZ / 1000);

  // 2-wire slave and memory map
  localparam logic [6:0]  TWI_DEV_ADDR    = 7'h50;
  localparam int unsigned MM_DEPTH        = 128;
  localparam logic [7:0]  MM_STATUS_ADDR  = 8'h02;
  localparam int unsigned MM_DNR_BIT      = 0;
  localparam logic [7:0]  MM_RESET_VAL    = 8'h00;

  // register offsets (byte addresses)
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_STATUS      = 8'h04;
  localparam logic [7:0]  REG_MASK        = 8'h08;
  localparam logic [7:0]  REG_STATE       = 8'h0c;

  // field positions
  localparam int unsigned CTRL_FORCE_LP   = 0;
  localparam int unsigned NUM_EV          = 2;
  localparam int unsigned EV_RESET_DONE   = 0;
  localparam int unsigned EV_HOST_WRITE   = 1;
  localparam int unsigned STATE_NOT_READY = 0;
  localparam int unsigned STATE_HOLD      = 1;
  localparam int unsigned STATE_SELECTED  = 2;
  localparam int unsigned STATE_LP_LIMIT  = 3;

  // reset values
  localparam logic [NUM_EV-1:0] MASK_RESET   = 2'h1;
  localparam logic              CTRL_LP_RESET = 1'b0;

  typedef enum logic [3:0] {
    TWI_IDLE, TWI_ADDR, TWI_ADDR_ACK, TWI_PTR, TWI_PTR_ACK,
    TWI_WDATA, TWI_WDATA_ACK, TWI_RDATA, TWI_RDATA_ACK
  } mlsc_twi_state_t;

  typedef enum logic [1:0] {
    RS_RUN, RS_HOLD, RS_INIT
  } mlsc_rst_state_t;
endpackage

//--- logic/mlsc_rst_if.sv
// reset sequencer to core link
interface mlsc_rst_if;
  logic hold;
  logic not_ready;
  logic done;

  modport seq  (output hold, output not_ready, output done);
  modport core (input hold, input not_ready, input done);
endinterface

//--- logic/mlsc_rst_seq.sv
// reset pin filter and reset/initialisation sequencer
module mlsc_rst_seq
  import mlsc_pkg::*;
#(
  parameter int unsigned RST_MIN  = RST_MIN_CYCLES,
  parameter int unsigned INIT_CYC = INIT_CYCLES
) (
  input  logic       core_clk,
  input  logic       nrst,
  input  logic       module_reset_n,
  mlsc_rst_if.seq    rs
);
  typedef struct packed {
    logic [1:0]      pin_q;
    mlsc_rst_state_t st;
    logic [15:0]     flt_cnt;
    logic [31:0]     init_cnt;
    logic            done;
  } mlsc_rst_reg_t;

  mlsc_rst_reg_t r;
  mlsc_rst_reg_t next_r;

  // sequence: filter the pin, hold while low, count init, then announce
  always_comb begin
    next_r       = r;
    next_r.done  = 1'b0;
    next_r.pin_q = {r.pin_q[0], module_reset_n};
    case (r.st)
      RS_HOLD: begin
        if (r.pin_q[1]) begin
          next_r.st       = RS_INIT;
          next_r.init_cnt = 32'h0;
        end
      end
      RS_INIT: begin
        if (r.init_cnt >= 32'(INIT_CYC - 1)) begin
          next_r.st   = RS_RUN;
          next_r.done = 1'b1;
        end else begin
          next_r.init_cnt = r.init_cnt + 32'h1;
        end
      end
      RS_RUN: begin
        next_r.st = RS_RUN;
      end
      default: begin
        next_r.st = RS_INIT;
      end
    endcase
    // short low pulses only count up, a long one forces a full reset
    if (!r.pin_q[1]) begin
      if (r.flt_cnt < 16'(RST_MIN)) begin
        next_r.flt_cnt = r.flt_cnt + 16'h1;
      end else begin
        next_r.st   = RS_HOLD;
        next_r.done = 1'b0;
      end
    end else begin
      next_r.flt_cnt = 16'h0;
    end
  end

  // power-up starts in init so completion is posted without a pin pulse
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r       <= '0;
      r.pin_q <= 2'h3;
      r.st    <= RS_INIT;
    end else begin
      r <= next_r;
    end
  end

  assign rs.hold      = (r.st == RS_HOLD);
  // stay not ready through the done pulse so the clear lands with the irq edge
  assign rs.not_ready = (r.st != RS_RUN) | r.done;
  assign rs.done      = r.done;
endmodule

//--- logic/mlsc_top.sv
// module low-speed control: select, reset, low power, present, interrupt, 2-wire slave
// Summary of operation
// - the 2-wire slave answers only while module select is low and drops traffic otherwise.
// - the memory map is reached through the 2-wire clock and data lines, served as a slave.
// - a reset pin held low longer than the minimum restores every setting to its default.
// - at reset completion the interrupt is raised and data-not-ready is cleared.
// - after power-up the completion interrupt is raised without any reset pulse.
// - the low power input limits the module's maximum power level.
// - the present pin is tied to ground so the host line reads low.
// - the interrupt output is pulled low to flag an unmasked reset-done or host-write event.
//
// The strobed register port and the placing of the registers were decided locally.
module mlsc_top
  import mlsc_pkg::*;
#(
  parameter int unsigned RST_MIN  = RST_MIN_CYCLES,
  parameter int unsigned INIT_CYC = INIT_CYCLES,
  parameter int unsigned DEPTH    = MM_DEPTH
) (
  input  logic        core_clk,
  input  logic        nrst,
  input  logic        module_select_n,
  input  logic        module_reset_n,
  input  logic        low_power_select,
  input  logic        scl_in,
  input  logic        sda_in,
  output logic        sda_out,
  output logic        sda_oe,
  output logic        interrupt_out_n,
  output logic        interrupt_oe,
  output logic        module_present_n,
  output logic        max_power_limited,
  input  logic [7:0]  reg_addr,
  input  logic [31:0] reg_wdata,
  input  logic        reg_wr,
  input  logic        reg_rd,
  output logic [31:0] reg_rdata
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [1:0]              sel_q;
    logic [1:0]              lp_q;
    logic [2:0]              scl_q;
    logic [2:0]              sda_q;
    mlsc_twi_state_t         st;
    logic                    rd;
    logic [7:0]              shreg;
    logic [3:0]              cnt;
    logic [7:0]              ptr;
    logic                    sda_low;
    logic [NUM_EV-1:0]       status;
    logic [NUM_EV-1:0]       mask;
    logic                    force_lp;
    logic                    lp_limit;
    logic                    irq;
    logic [31:0]             rdata;
    logic [DEPTH-1:0][7:0]   mem;
  } mlsc_top_reg_t;

  mlsc_top_reg_t r;
  mlsc_top_reg_t next_r;
  mlsc_rst_if    rs ();

  // reset filter and init sequencer
  mlsc_rst_seq #(
    .RST_MIN  (RST_MIN),
    .INIT_CYC (INIT_CYC)
  ) u_rst_seq (
    .core_clk       (core_clk),
    .nrst           (nrst),
    .module_reset_n (module_reset_n),
    .rs             (rs)
  );

  // register offset match, used by both write and read decode
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offs);
    reg_hit = (addr == offs);
  endfunction

  // memory map byte as seen by the host; status byte carries data-not-ready
  function automatic logic [7:0] mm_byte(input mlsc_top_reg_t s, input logic nrdy);
    logic [7:0] b;
    b = s.mem[s.ptr[AW-1:0]];
    if (s.ptr == MM_STATUS_ADDR) begin
      b[MM_DNR_BIT] = nrdy;
    end
    mm_byte = b;
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic twi_start;
  logic twi_stop;
  logic selected;
  logic [7:0] rd_byte;
  logic [NUM_EV-1:0] ev_set;
  logic [NUM_EV-1:0] ev_clr;

  // bus conditions from the second and third sync stages only
  assign scl_rise  = r.scl_q[1] & ~r.scl_q[2];
  assign scl_fall  = ~r.scl_q[1] & r.scl_q[2];
  assign twi_start = r.scl_q[1] & r.scl_q[2] & ~r.sda_q[1] & r.sda_q[2];
  assign twi_stop  = r.scl_q[1] & r.scl_q[2] & r.sda_q[1] & ~r.sda_q[2];
  assign selected  = ~r.sel_q[1];
  assign rd_byte   = mm_byte(r, rs.not_ready);

  always_comb begin
    next_r       = r;
    ev_set       = '0;
    ev_clr       = '0;
    // two-flop synchronisers for select and low power, three-flop for clock and data
    next_r.sel_q = {r.sel_q[0], module_select_n};
    next_r.lp_q  = {r.lp_q[0], low_power_select};
    next_r.scl_q = {r.scl_q[1:0], scl_in};
    next_r.sda_q = {r.sda_q[1:0], sda_in};

    // 2-wire slave; a deselect mid-transfer drops it and frees the line
    if (!selected || twi_stop) begin
      next_r.st      = TWI_IDLE;
      next_r.sda_low = 1'b0;
    end else if (twi_start) begin
      next_r.st      = TWI_ADDR;
      next_r.cnt     = 4'h0;
      next_r.sda_low = 1'b0;
    end else begin
      case (r.st)
        TWI_ADDR, TWI_PTR, TWI_WDATA: begin
          if (scl_rise) begin
            next_r.shreg = {r.shreg[6:0], r.sda_q[1]};
            next_r.cnt   = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == 4'h8) begin
            next_r.cnt = 4'h0;
            if (r.st == TWI_ADDR) begin
              if (r.shreg[7:1] == TWI_DEV_ADDR) begin
                next_r.rd      = r.shreg[0];
                next_r.sda_low = 1'b1;
                next_r.st      = TWI_ADDR_ACK;
              end else begin
                next_r.st = TWI_IDLE;
              end
            end else if (r.st == TWI_PTR) begin
              next_r.ptr     = r.shreg;
              next_r.sda_low = 1'b1;
              next_r.st      = TWI_PTR_ACK;
            end else begin
              // settings stay at default while the reset is held
              if (!rs.hold) begin
                next_r.mem[r.ptr[AW-1:0]] = r.shreg;
                ev_set[EV_HOST_WRITE]     = 1'b1;
              end
              next_r.sda_low = 1'b1;
              next_r.st      = TWI_WDATA_ACK;
            end
          end
        end
        TWI_ADDR_ACK: begin
          if (scl_fall) begin
            if (r.rd) begin
              next_r.shreg   = rd_byte;
              next_r.sda_low = ~rd_byte[7];
              next_r.st      = TWI_RDATA;
            end else begin
              next_r.sda_low = 1'b0;
              next_r.st      = TWI_PTR;
            end
          end
        end
        TWI_PTR_ACK: begin
          if (scl_fall) begin
            next_r.sda_low = 1'b0;
            next_r.st      = TWI_WDATA;
          end
        end
        TWI_WDATA_ACK: begin
          if (scl_fall) begin
            next_r.sda_low = 1'b0;
            next_r.ptr     = r.ptr + 8'h1;
            next_r.st      = TWI_WDATA;
          end
        end
        TWI_RDATA: begin
          // shift out msb first on falling clock, release after bit 0
          if (scl_fall) begin
            if (r.cnt == 4'h7) begin
              next_r.cnt     = 4'h0;
              next_r.sda_low = 1'b0;
              next_r.ptr     = r.ptr + 8'h1;
              next_r.st      = TWI_RDATA_ACK;
            end else begin
              next_r.cnt     = r.cnt + 4'h1;
              next_r.shreg   = {r.shreg[6:0], 1'b0};
              next_r.sda_low = ~r.shreg[6];
            end
          end
        end
        TWI_RDATA_ACK: begin
          if (scl_rise) begin
            next_r.rd = ~r.sda_q[1];
          end else if (scl_fall) begin
            // master ack continues the burst, nack ends it
            if (r.rd) begin
              next_r.shreg   = rd_byte;
              next_r.sda_low = ~rd_byte[7];
              next_r.st      = TWI_RDATA;
            end else begin
              next_r.st = TWI_IDLE;
            end
          end
        end
        TWI_IDLE: begin
          next_r.sda_low = 1'b0;
        end
        default: begin
          next_r.st      = TWI_IDLE;
          next_r.sda_low = 1'b0;
        end
      endcase
    end
    if (r.st == TWI_RDATA_ACK && scl_fall && !r.rd) begin
      next_r.rd = 1'b1;
    end

    // software register writes
    if (reg_wr) begin
      if (reg_hit(reg_addr, REG_CTRL)) begin
        next_r.force_lp = reg_wdata[CTRL_FORCE_LP];
      end
      if (reg_hit(reg_addr, REG_STATUS)) begin
        ev_clr = reg_wdata[NUM_EV-1:0];
      end
      if (reg_hit(reg_addr, REG_MASK)) begin
        next_r.mask = reg_wdata[NUM_EV-1:0];
      end
    end

    // completion event; a set in the clearing cycle wins
    ev_set[EV_RESET_DONE] = rs.done;
    next_r.status = (r.status & ~ev_clr) | ev_set;

    // held reset brings every setting back to its default
    if (rs.hold) begin
      next_r.mem      = {DEPTH{MM_RESET_VAL}};
      next_r.force_lp = CTRL_LP_RESET;
      next_r.mask     = MASK_RESET;
    end

    // power limit from the pin or the software override
    next_r.lp_limit = r.lp_q[1] | next_r.force_lp;
    next_r.irq      = |(next_r.status & next_r.mask);

    // software register reads, data in the following cycle
    if (reg_rd) begin
      next_r.rdata = 32'h0;
      if (reg_hit(reg_addr, REG_CTRL)) begin
        next_r.rdata[CTRL_FORCE_LP] = r.force_lp;
      end
      if (reg_hit(reg_addr, REG_STATUS)) begin
        next_r.rdata[NUM_EV-1:0] = r.status;
      end
      if (reg_hit(reg_addr, REG_MASK)) begin
        next_r.rdata[NUM_EV-1:0] = r.mask;
      end
      if (reg_hit(reg_addr, REG_STATE)) begin
        next_r.rdata[STATE_NOT_READY] = rs.not_ready;
        next_r.rdata[STATE_HOLD]      = rs.hold;
        next_r.rdata[STATE_SELECTED]  = selected;
        next_r.rdata[STATE_LP_LIMIT]  = r.lp_limit;
      end
    end
  end

  // one state register; line pins idle high so no false edges after reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r          <= '0;
      r.sel_q    <= 2'h3;
      r.scl_q    <= 3'h7;
      r.sda_q    <= 3'h7;
      r.st       <= TWI_IDLE;
      r.mask     <= MASK_RESET;
      r.force_lp <= CTRL_LP_RESET;
      r.mem      <= {DEPTH{MM_RESET_VAL}};
    end else begin
      r <= next_r;
    end
  end

  // open-drain lines: only ever pull low
  assign sda_out           = 1'b0;
  assign sda_oe            = r.sda_low;
  assign interrupt_out_n   = ~r.irq;
  assign interrupt_oe      = r.irq;
  assign module_present_n  = 1'b0;
  assign max_power_limited = r.lp_limit;
  assign reg_rdata         = r.rdata;
endmodule

//--- verification/mlsc_top_assertions.sv
// property checks on the ports of the low-speed control top
module mlsc_top_assertions
  import mlsc_pkg::*;
#(
  parameter int unsigned RST_MIN  = RST_MIN_CYCLES,
  parameter int unsigned INIT_CYC = INIT_CYCLES
) (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        module_select_n,
  input wire logic        module_reset_n,
  input wire logic        low_power_select,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        interrupt_out_n,
  input wire logic        interrupt_oe,
  input wire logic        module_present_n,
  input wire logic        max_power_limited,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata
);
  logic [7:0]  lo_cnt;
  logic [31:0] quiet;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // low run of the reset pin, and time since the last run long enough to count
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lo_cnt <= 8'h00;
      quiet  <= 32'h0;
    end else begin
      lo_cnt <= module_reset_n ? 8'h00 : lo_cnt + 8'h01;
      quiet  <= (32'(lo_cnt) > RST_MIN) ? 32'h0 : quiet + 32'h1;
    end
  end
  present_low_a: assert property (module_present_n == 1'h0)
    else $error("present pin not low");
  irq_oe_pair_a: assert property (interrupt_oe == !interrupt_out_n)
    else $error("interrupt enable disagrees with pin");
  sda_zero_a: assert property (sda_out == 1'h0)
    else $error("data line driven high");
  desel_quiet_a: assert property (module_select_n [*6] |-> !sda_oe)
    else $error("data line pulled while deselected");
  lp_follow_a: assert property (low_power_select [*6] |-> max_power_limited)
    else $error("power limit not applied");
  mask_off_a: assert property (reg_wr && reg_addr == REG_MASK
    && reg_wdata[1:0] == 2'h0 |=> interrupt_out_n) else $error("masked interrupt shown");
  hold_state_a: assert property (reg_rd && reg_addr == REG_STATE
    && 32'(lo_cnt) > RST_MIN + 5 |=> reg_rdata[STATE_HOLD] && reg_rdata[STATE_NOT_READY])
    else $error("long reset pulse not holding");
  short_pulse_a: assert property (reg_rd && reg_addr == REG_STATE
    && quiet > INIT_CYC + 10 |=> !reg_rdata[STATE_NOT_READY]) else $error("spurious reset");
endmodule

bind mlsc_top mlsc_top_assertions #(.RST_MIN(RST_MIN), .INIT_CYC(INIT_CYC)) chk_i (
  .core_clk(core_clk), .nrst(nrst), .module_select_n(module_select_n),
  .module_reset_n(module_reset_n), .low_power_select(low_power_select),
  .sda_out(sda_out), .sda_oe(sda_oe), .interrupt_out_n(interrupt_out_n),
  .interrupt_oe(interrupt_oe), .module_present_n(module_present_n),
  .max_power_limited(max_power_limited), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

//--- verification/mlsc_host_model.sv
// host board model: 2-wire master driving the clock, with a pull-up on data
module mlsc_host_model (
  input  wire logic core_clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sda_drv;
  int   q = 80;
  // open drain: pull-up wins unless either side pulls low
  assign sda = sda_drv & ~sda_oe;
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  // start or repeated start; clock idles high between frames
  task automatic start();
    @(posedge core_clk) #7;
    #q sda_drv = 1'h1;
    #q scl = 1'h1;
    #q sda_drv = 1'h0;
    #q scl = 1'h0;
  endtask
  // data moves a quarter after the fall so no edge looks like start or stop
  task automatic bit_io(input logic b, output logic r);
    #q sda_drv = b;
    #q scl = 1'h1;
    #q r = sda;
    #q scl = 1'h0;
  endtask
  task automatic stop();
    #q sda_drv = 1'h0;
    #q scl = 1'h1;
    #q sda_drv = 1'h1;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'h1, ack);
  endtask
  // reads one byte and answers with nack to end the read
  task automatic get_byte(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'h1, b[i]);
    bit_io(1'h1, r);
  endtask
endmodule

//--- verification/mlsc_top_test.sv
// self-checking bench of the low-speed control top
module mlsc_top_test
  import mlsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned RMIN = 4;
  localparam int unsigned INIT = 20;
  logic        core_clk, nrst, module_select_n, module_reset_n, low_power_select;
  logic        scl, sda, sda_out, sda_oe, irq_n, irq_oe, present_n, lim;
  logic [7:0]  reg_addr, b;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic        reg_wr, reg_rd, ack;
  int          failures, n_tests;

  mlsc_top #(.RST_MIN(RMIN), .INIT_CYC(INIT)) DUT (
    .core_clk(core_clk), .nrst(nrst), .module_select_n(module_select_n),
    .module_reset_n(module_reset_n), .low_power_select(low_power_select),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .interrupt_out_n(irq_n), .interrupt_oe(irq_oe), .module_present_n(present_n),
    .max_power_limited(lim), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  mlsc_host_model host (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bus cycles: strobe for one edge, dropped before the next cycle starts
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    // data hold until the next read strobe; take them at the following edge
    @(posedge core_clk);
    v = reg_rdata;
  endtask
  // set the map pointer, then read one byte through a repeated start
  task automatic mm_read(input logic [7:0] p, output logic [7:0] v);
    host.start();
    host.put_byte(8'ha0, ack);
    host.put_byte(p, ack);
    host.start();
    host.put_byte(8'ha1, ack);
    host.get_byte(v);
    host.stop();
  endtask
  // bounded wait; running out ends the run as a failure
  task automatic wait_irq(input int lim_cyc);
    int i;
    for (i = 0; i < lim_cyc && irq_n !== 1'h0; i++) @(posedge core_clk);
    if (i == lim_cyc) begin
      chk("interrupt wait", irq_n, 32'h0);
      complete_run();
    end
  endtask
  task automatic t_power_up();
    rd(REG_STATE, d);
    chk("not ready early", d[STATE_NOT_READY], 32'h1);
    wait_irq(INIT + 10);
    rd(REG_STATE, d);
    chk("ready after init", d[STATE_NOT_READY], 32'h0);
    rd(REG_STATUS, d);
    chk("status after init", d, 32'h1);
    chk("present pin", present_n, 32'h0);
    chk("irq enable", irq_oe, 32'h1);
  endtask
  task automatic t_irq();
    wr(REG_MASK, 32'h0);
    @(negedge core_clk);
    chk("irq masked", irq_n, 32'h1);
    wr(REG_MASK, 32'h1);
    @(negedge core_clk);
    chk("irq unmasked", irq_n, 32'h0);
    wr(REG_STATUS, 32'h1);
    @(negedge core_clk);
    chk("irq cleared", irq_n, 32'h1);
    rd(8'h10, d);
    chk("unmapped read", d, 32'h0);
  endtask
  task automatic t_low_power();
    @(posedge core_clk);
    low_power_select <= 1'h1;
    repeat (6) @(posedge core_clk);
    rd(REG_STATE, d);
    chk("limit bit", d[STATE_LP_LIMIT], 32'h1);
    chk("limit pin on", lim, 32'h1);
    low_power_select <= 1'h0;
    repeat (6) @(posedge core_clk);
    chk("limit pin off", lim, 32'h0);
    wr(REG_CTRL, 32'h1);
    repeat (3) @(negedge core_clk);
    chk("forced limit", lim, 32'h1);
  endtask
  // selected write then slow read back; deselected frame is ignored
  task automatic t_twi();
    wr(REG_MASK, 32'h2);
    host.start();
    host.put_byte(8'ha0, ack);
    chk("addr ack", ack, 32'h0);
    host.put_byte(8'h10, ack);
    host.put_byte(8'h5a, ack);
    chk("data ack", ack, 32'h0);
    host.q = 160;
    mm_read(8'h10, b);
    host.q = 80;
    chk("read back", b, 32'h5a);
    chk("write irq", irq_n, 32'h0);
    rd(REG_STATUS, d);
    chk("write event", d, 32'h2);
    wr(REG_STATUS, 32'h2);
    @(posedge core_clk);
    module_select_n <= 1'h1;
    host.start();
    host.put_byte(8'ha0, ack);
    chk("deselected ack", ack, 32'h1);
    host.put_byte(8'h10, ack);
    host.put_byte(8'h33, ack);
    host.stop();
    rd(REG_STATUS, d);
    chk("deselected event", d, 32'h0);
    module_select_n <= 1'h0;
  endtask
  task automatic t_reset();
    @(posedge core_clk);
    module_reset_n <= 1'h0;
    repeat (RMIN) @(posedge core_clk);
    module_reset_n <= 1'h1;
    repeat (6) @(posedge core_clk);
    rd(REG_CTRL, d);
    chk("short pulse", d, 32'h1);
    module_reset_n <= 1'h0;
    repeat (10) @(posedge core_clk);
    rd(REG_STATE, d);
    chk("hold state", d[1:0], 32'h3);
    mm_read(MM_STATUS_ADDR, b);
    chk("map not ready", b, 32'h1);
    @(posedge core_clk);
    module_reset_n <= 1'h1;
    wait_irq(INIT + 12);
    rd(REG_STATE, d);
    chk("ready after reset", d[STATE_NOT_READY], 32'h0);
    rd(REG_CTRL, d);
    chk("ctrl default", d, 32'h0);
    rd(REG_MASK, d);
    chk("mask default", d, 32'h1);
    mm_read(MM_STATUS_ADDR, b);
    chk("map ready", b, 32'h0);
  endtask
  initial begin
    nrst = 1'h0;
    module_select_n = 1'h0;
    module_reset_n = 1'h1;
    low_power_select = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    failures = 0;
    n_tests = 0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'h1;
    t_power_up();
    t_irq();
    t_low_power();
    t_twi();
    t_reset();
    complete_run();
  end
endmodule
